// >>> hdl/exc_unit.v
// Exception and interrupt unit with AXI4-Lite register access
`timescale 1ns/1ps
`include "exc_unit_defs.vh"
// Functional notes
// - System call traps via common vector
// - Save return PC, delay flag when level clear
// - Breakpoint traps via common vector
// - Breakpoint code bits ignored by decode
// - Undefined major opcode is reserved
// - Undefined function or register_immediate_opgroup minor reserved
// - Undefined coprocessor rs or rt reserved
// - Wide ops reserved outside kernel unless enabled
// - Reserved trap, common vector, cause code
// - Unusable coprocessor traps
// - System coprocessor traps outside kernel only
// - No FPU makes float ops unusable
// - Unusable code plus coprocessor number
// - Float exception, common vector, cause code
// - Eight interrupts, five of the six active low inputs used
// - Software pending bits set and cleared
// - Individual masks and global enable
// - Narrow mode vector chosen by boot bit
// - Wide mode vector sign extended
// - Interrupt wakes doze or halt
// - Timer pending cleared by compare write
// - No interrupts with either level set
module exc_unit #(
  parameter FPU_PRESENT = 1
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire instr_valid,
  input wire [31:0] instr_word,
  input wire [63:0] instr_pc,
  input wire in_delay_slot,
  input wire [63:0] branch_pc,
  input wire fpu_exception,
  input wire timer_match,
  input wire [5:0] hw_int_n,
  input wire low_power,
  output reg exc_taken,
  output reg [4:0] exc_code,
  output reg [63:0] exc_vector,
  output reg wake
);
  reg [31:0] status_q;
  reg [4:0] exc_code_q;
  reg [1:0] cop_err_q;
  reg delay_slot_flag_q;
  reg [1:0] soft_pend_q;
  reg timer_pend_q;
  reg [63:0] exception_return_pc_q;
  reg [31:0] compare_q;
  reg wide_mode_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_have_q;
  reg w_have_q;

  wire exception_level_flag = status_q[`ST_EXL];
  wire error_level_flag = status_q[`ST_ERL];
  wire global_interrupt_enable = status_q[`ST_IE];
  wire [7:0] interrupt_mask_field = status_q[`ST_IM_HI:`ST_IM_LO];
  wire boot_vector_select = status_q[`ST_BEV];
  wire kernel_wide_addr_bit = status_q[`ST_KX];
  wire [3:0] coproc_usable_bit = status_q[`ST_CU_HI:`ST_CU_LO];
  wire kernel_mode = (status_q[`ST_KSU_HI:`ST_KSU_LO] == 2'h0) || exception_level_flag
    || error_level_flag;
  // Hardware lines are level sensitive; never latched here
  wire [5:0] hw_pend = ~hw_int_n;
  wire [7:0] interrupt_pending_bits = {timer_pend_q, hw_pend[4:0], soft_pend_q};
  wire [7:0] int_live = interrupt_pending_bits & interrupt_mask_field;
  wire int_req = (|int_live) && global_interrupt_enable && !exception_level_flag
    && !error_level_flag;

  wire dec_sys;
  wire dec_bp;
  wire dec_ri;
  wire dec_cpu;
  wire [1:0] dec_cop;

  instr_classifier u_classifier (
    .instr(instr_word),
    .kernel_mode(kernel_mode),
    .wide_enabled(kernel_wide_addr_bit),
    .coproc_usable_bit(coproc_usable_bit),
    .fpu_present(FPU_PRESENT != 0),
    .is_system_call_instr(dec_sys),
    .is_break(dec_bp),
    .is_reserved(dec_ri),
    .is_cop_unusable(dec_cpu),
    .cop_num(dec_cop)
  );

  function [31:0] merge;
    input [31:0] old;
    input [31:0] val;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          merge[i*8 +: 8] = val[i*8 +: 8];
    end
  endfunction

  // Priority: interrupt, unusable, reserved, system_call_instr, break, float
  reg take;
  reg [4:0] code_d;
  always @* begin
    take = 1'b1;
    code_d = `EXC_INT;
    if (int_req)
      code_d = `EXC_INT;
    else if (instr_valid && dec_cpu)
      code_d = `EXC_CPU;
    else if (instr_valid && dec_ri)
      code_d = `EXC_RI;
    else if (instr_valid && dec_sys)
      code_d = `EXC_SYS;
    else if (instr_valid && dec_bp)
      code_d = `EXC_BP;
    else if (instr_valid && fpu_exception)
      code_d = `EXC_FPE;
    else
      take = 1'b0;
  end

  wire [31:0] vec_lo = boot_vector_select ? `VEC_BOOT : `VEC_NORMAL;
  wire [63:0] vec_full = wide_mode_q ? {`VEC_SEXT, vec_lo} : {32'h0000_0000, vec_lo};

  // Bus write channel
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire [7:0] wa = aw_have_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wd = w_have_q ? wdata_q : s_axi_wdata;
  wire [3:0] ws = w_have_q ? wstrb_q : s_axi_wstrb;
  wire aw_ok = aw_have_q || (s_axi_awvalid && s_axi_awready);
  wire w_ok = w_have_q || (s_axi_wvalid && s_axi_wready);
  wire wr_go = aw_ok && w_ok;
  wire wr_hit = (wa[7:5] == 3'h0) && (wa[1:0] == 2'h0);
  wire [31:0] cause_rd = {delay_slot_flag_q, 1'b0, cop_err_q, 12'h000, interrupt_pending_bits,
    1'b0, exc_code_q, 2'h0};
  wire [31:0] st_new = merge(status_q, wd, ws);
  wire [31:0] ca_new = merge(cause_rd, wd, ws);
  wire [31:0] ct_new = merge({31'h0000_0000, wide_mode_q}, wd, ws);
  wire wr_status = wr_go && wa == `OFF_STATUS;
  wire wr_cause = wr_go && wa == `OFF_CAUSE;
  wire wr_compare = wr_go && wa == `OFF_COMPARE;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_have_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_have_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
      end
    end
  end

  // Architectural state
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= `ST_RESET;
      exc_code_q <= `EXC_INT;
      cop_err_q <= 2'h0;
      delay_slot_flag_q <= 1'b0;
      soft_pend_q <= 2'h0;
      timer_pend_q <= 1'b0;
      exception_return_pc_q <= 64'h0000_0000_0000_0000;
      compare_q <= 32'h0000_0000;
      wide_mode_q <= 1'b0;
      exc_taken <= 1'b0;
      exc_code <= `EXC_INT;
      exc_vector <= 64'h0000_0000_0000_0000;
      wake <= 1'b0;
    end else begin
      exc_taken <= take;
      wake <= low_power && (|int_live);
      if (wr_status)
        status_q <= st_new & `ST_WMASK;
      if (wr_cause)
        soft_pend_q <= ca_new[`CA_IP_LO+1:`CA_IP_LO];
      if (wr_compare)
        compare_q <= merge(compare_q, wd, ws);
      if (wr_go && wa == `OFF_CTRL)
        wide_mode_q <= ct_new[0];
      // Timer set wins over a same-cycle clear
      if (timer_match)
        timer_pend_q <= 1'b1;
      else if (wr_compare || (wr_cause && !ca_new[`CA_IP_HI]))
        timer_pend_q <= 1'b0;
      if (take) begin
        exc_code_q <= code_d;
        exc_code <= code_d;
        exc_vector <= vec_full;
        if (code_d == `EXC_CPU)
          cop_err_q <= dec_cop;
        status_q[`ST_EXL] <= 1'b1;
        if (!exception_level_flag) begin
          delay_slot_flag_q <= in_delay_slot;
          exception_return_pc_q <= in_delay_slot ? branch_pc : instr_pc;
        end
      end
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr)
        `OFF_STATUS: s_axi_rdata <= status_q;
        `OFF_CAUSE: s_axi_rdata <= cause_rd;
        `OFF_EPC_LO: s_axi_rdata <= exception_return_pc_q[31:0];
        `OFF_EPC_HI: s_axi_rdata <= exception_return_pc_q[63:32];
        `OFF_COMPARE: s_axi_rdata <= compare_q;
        `OFF_CTRL: s_axi_rdata <= {31'h0000_0000, wide_mode_q};
        `OFF_VECT_LO: s_axi_rdata <= vec_full[31:0];
        `OFF_VECT_HI: s_axi_rdata <= vec_full[63:32];
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
  end
endmodule

// >>> hdl/exc_unit_defs.vh
// Constants for the exception and interrupt unit
`ifndef EXC_UNIT_DEFS_VH
`define EXC_UNIT_DEFS_VH
// Register byte offsets
`define OFF_STATUS 8'h00
`define OFF_CAUSE 8'h04
`define OFF_EPC_LO 8'h08
`define OFF_EPC_HI 8'h0C
`define OFF_COMPARE 8'h10
`define OFF_CTRL 8'h14
`define OFF_VECT_LO 8'h18
`define OFF_VECT_HI 8'h1C
// Status fields
`define ST_IE 0
`define ST_EXL 1
`define ST_ERL 2
`define ST_KSU_LO 3
`define ST_KSU_HI 4
`define ST_KX 7
`define ST_IM_LO 8
`define ST_IM_HI 15
`define ST_BEV 22
`define ST_CU_LO 28
`define ST_CU_HI 31
`define ST_WMASK 32'hF04F_FF9F
`define ST_RESET 32'h0040_0004
// Cause fields
`define CA_EXC_LO 2
`define CA_EXC_HI 6
`define CA_IP_LO 8
`define CA_IP_HI 15
`define CA_CE_LO 28
`define CA_CE_HI 29
`define CA_BD 31
// Cause codes
`define EXC_INT 5'h00
`define EXC_SYS 5'h08
`define EXC_BP 5'h09
`define EXC_RI 5'h0A
`define EXC_CPU 5'h0B
`define EXC_FPE 5'h0F
// Opcode groups
`define OP_FUNCTION_FIELD_OPGROUP 6'h00
`define OP_REGISTER_IMMEDIATE_OPGROUP 6'h01
`define OP_COP0 6'h10
`define OP_COP1 6'h11
`define OP_COP2 6'h12
`define OP_COP1X 6'h13
`define FN_SYSTEM_CALL_INSTR 6'h0C
`define FN_BREAK 6'h0D
// Vectors and bus response codes
`define VEC_NORMAL 32'h8000_0180
`define VEC_BOOT 32'hBFC0_0380
`define VEC_SEXT 32'hFFFF_FFFF
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> hdl/instr_classifier.v
// Instruction decode checks for reserved and coprocessor exceptions
`timescale 1ns/1ps
`include "exc_unit_defs.vh"
module instr_classifier (
  input wire [31:0] instr,
  input wire kernel_mode,
  input wire wide_enabled,
  input wire [3:0] coproc_usable_bit,
  input wire fpu_present,
  output reg is_system_call_instr,
  output reg is_break,
  output reg is_reserved,
  output reg is_cop_unusable,
  output reg [1:0] cop_num
);
  wire [5:0] major = instr[31:26];
  wire [5:0] func = instr[5:0];
  wire [4:0] rs = instr[25:21];
  wire [4:0] rt = instr[20:16];
  reg wide_op;
  reg is_cop;

  function minor_function_field_opgroup_ok;
    input [5:0] f;
    begin
      case (f)
        6'h01, 6'h05, 6'h0E, 6'h15, 6'h28, 6'h29, 6'h35, 6'h37, 6'h39, 6'h3D:
          minor_function_field_opgroup_ok = 1'b0;
        default: minor_function_field_opgroup_ok = 1'b1;
      endcase
    end
  endfunction

  function register_immediate_opgroup_ok;
    input [4:0] r;
    begin
      register_immediate_opgroup_ok = (r[4:3] == 2'h0 && r[1] == 1'b0) || (r[4:3] == 2'h1 && r[2] == 1'b0)
        || (r[4:3] == 2'h2 && r[2] == 1'b0);
    end
  endfunction

  function cop_rs_ok;
    input [4:0] r;
    input [4:0] t;
    begin
      if (r[4])
        cop_rs_ok = 1'b1;
      else if (r == 5'h08)
        cop_rs_ok = (t[4:2] == 3'h0);
      else
        cop_rs_ok = (r[2] == 1'b0);
    end
  endfunction

  always @* begin
    is_system_call_instr = 1'b0;
    is_break = 1'b0;
    is_reserved = 1'b0;
    is_cop_unusable = 1'b0;
    cop_num = 2'h0;
    wide_op = 1'b0;
    is_cop = 1'b0;
    case (major)
      `OP_FUNCTION_FIELD_OPGROUP: begin
        is_system_call_instr = (func == `FN_SYSTEM_CALL_INSTR);
        is_break = (func == `FN_BREAK);
        is_reserved = !minor_function_field_opgroup_ok(func);
        wide_op = (func[5:3] == 3'h7) || (func[5:2] == 4'h5) || (func == 6'h14)
          || (func == 6'h16) || (func == 6'h17) || (func[5:2] == 4'h7 && func[1:0] != 2'h1);
      end
      `OP_REGISTER_IMMEDIATE_OPGROUP: is_reserved = !register_immediate_opgroup_ok(rt);
      `OP_COP0, `OP_COP1, `OP_COP2: begin
        is_cop = 1'b1;
        cop_num = major[1:0];
      end
      `OP_COP1X: begin
        is_cop = 1'b1;
        cop_num = 2'h1;
      end
      6'h18, 6'h19, 6'h1A, 6'h1B, 6'h27, 6'h2C, 6'h2D, 6'h34, 6'h37, 6'h3C, 6'h3F:
        wide_op = 1'b1;
      6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h3B, 6'h3A, 6'h32, 6'h36, 6'h3E, 6'h33:
        is_reserved = 1'b1;
      default: is_reserved = 1'b0;
    endcase
    if (wide_op && !kernel_mode && !wide_enabled)
      is_reserved = 1'b1;
    if (is_cop) begin
      if (cop_num == 2'h0)
        is_cop_unusable = !kernel_mode && !coproc_usable_bit[0];
      else if (cop_num == 2'h1 && !fpu_present)
        is_cop_unusable = 1'b1;
      else
        is_cop_unusable = !coproc_usable_bit[cop_num];
      if (!is_cop_unusable && major != `OP_COP1X && !cop_rs_ok(rs, rt))
        is_reserved = 1'b1;
    end
  end
endmodule

// >>> sim/exc_unit_bench.sv
// Directed bench for the exception unit
`timescale 1ns/1ps
`include "exc_unit_defs.vh"
module exc_unit_bench;
  logic aclk, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, instr_valid = 1'h0, in_delay_slot = 1'h0;
  logic fpu_exception = 1'h0, timer_match = 1'h0, low_power = 1'h0, cw, tk;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, instr_word = 32'h0, sw, iw;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [63:0] instr_pc = 64'h0, branch_pc = 64'h0;
  logic [5:0] raise = 6'h0, drop = 6'h0, hw_int_n;
  logic [4:0] c;
  logic [70:0] tbl [13];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, exc_taken, wake;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [4:0] exc_code;
  wire [63:0] exc_vector;
  int n_fail = 0, n_tests = 0, n_taken = 0, cyc = 0, k;
  exc_unit exc_unit_i (.*);
  irq_source irq_source_i (.aclk(aclk), .raise(raise), .drop(drop), .hw_int_n(hw_int_n));
  initial begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (exc_taken === 1'h1) n_taken <= n_taken + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_of_test;
    end
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [33:0] e,
    input string n);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(n, e, {s_axi_rresp, s_axi_rdata & m});
  endtask
  task automatic ex(input logic [31:0] w, input logic [63:0] pc, input logic ds, fe, t,
    input logic [4:0] cd);
    @(posedge aclk);
    instr_valid <= 1'h1;
    instr_word <= w;
    instr_pc <= pc;
    branch_pc <= pc - 64'h4;
    in_delay_slot <= ds;
    fpu_exception <= fe;
    @(posedge aclk);
    instr_valid <= 1'h0;
    fpu_exception <= 1'h0;
    #1;
    chk("exc_taken", t, exc_taken);
    if (t) chk("exc_code", cd, exc_code);
  endtask
  task automatic w5;
    repeat (5) @(posedge aclk);
    #1;
  endtask
  initial begin
    tbl = '{{1'h1, 32'h0040_0000, 32'hEC00_0000, 1'h1, `EXC_RI},
      {1'h1, 32'h0040_0000, 32'h0000_0005, 1'h1, `EXC_RI},
      {1'h1, 32'h0040_0000, 32'h041F_0000, 1'h1, `EXC_RI},
      {1'h1, 32'h0040_0000, 32'h40E0_0000, 1'h1, `EXC_RI},
      {1'h1, 32'h0040_0000, 32'h411F_0000, 1'h1, `EXC_RI},
      {1'h0, 32'h0000_0010, 32'h0000_0014, 1'h1, `EXC_RI},
      {1'h0, 32'h0000_0000, 32'h0000_0014, 1'h0, 5'h00},
      {1'h0, 32'h0000_0010, 32'h4800_0000, 1'h1, `EXC_CPU},
      {1'h0, 32'h0000_0000, 32'h4400_0000, 1'h1, `EXC_CPU},
      {1'h0, 32'h2000_0000, 32'h4400_0000, 1'h0, 5'h00},
      {1'h0, 32'h0000_0010, 32'h4000_0000, 1'h1, `EXC_CPU},
      {1'h0, 32'h0000_0000, 32'h4000_0000, 1'h0, 5'h00},
      {1'h0, 32'h1000_0010, 32'h4000_0000, 1'h0, 5'h00}};
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`OFF_STATUS, 32'hFFFF_FFFF, `ST_RESET, "status");
    rd(8'h20, 32'hFFFF_FFFF, 34'h2_0000_0000, "unmapped");
    $display("test reset done");
    wr(`OFF_STATUS, 32'h0);
    wr(`OFF_CTRL, 32'h0);
    ex(32'h0000_000C, 64'h100, 1'h1, 1'h0, 1'h1, `EXC_SYS);
    chk("vector", `VEC_NORMAL, exc_vector[31:0]);
    rd(`OFF_EPC_LO, 32'hFFFF_FFFF, 32'hFC, "return pc");
    rd(`OFF_CAUSE, 32'h8000_007C, 32'h8000_0020, "cause");
    ex(32'h03FF_FFCD, 64'h200, 1'h0, 1'h0, 1'h1, `EXC_BP);
    rd(`OFF_EPC_LO, 32'hFFFF_FFFF, 32'hFC, "return pc");
    $display("test trap done");
    for (int i = 0; i < 13; i++) begin
      {cw, sw, iw, tk, c} = tbl[i];
      wr(`OFF_CTRL, {31'h0, cw});
      wr(`OFF_STATUS, sw);
      ex(iw, 64'h300, 1'h0, 1'h0, tk, c);
      if (tk && cw) chk("vector", {`VEC_SEXT, `VEC_BOOT}, exc_vector);
      if (tk && !cw) chk("vector", `VEC_NORMAL, exc_vector[31:0]);
      if (c == `EXC_CPU) rd(`OFF_CAUSE, 32'h3000_0000, {iw[27:26], 28'h0}, "unit");
    end
    wr(`OFF_STATUS, 32'h0);
    ex(32'h0, 64'h400, 1'h0, 1'h1, 1'h1, `EXC_FPE);
    $display("test decode done");
    wr(`OFF_STATUS, 32'h0000_0001);
    k = n_taken;
    raise <= 6'h01;
    w5;
    chk("masked take", k, n_taken);
    wr(`OFF_STATUS, 32'h0000_0401);
    w5;
    chk("irq take", k + 1, n_taken);
    chk("irq code", `EXC_INT, exc_code);
    wr(`OFF_STATUS, 32'h0000_0407);
    low_power <= 1'h1;
    w5;
    chk("level block", k + 1, n_taken);
    chk("wake", 1'h1, wake);
    raise <= 6'h0;
    drop <= 6'h01;
    low_power <= 1'h0;
    wr(`OFF_STATUS, 32'h0000_0401);
    w5;
    chk("released", k + 1, n_taken);
    chk("wake", 1'h0, wake);
    wr(`OFF_CAUSE, 32'h0000_0100);
    wr(`OFF_STATUS, 32'h0000_0101);
    w5;
    chk("soft take", k + 2, n_taken);
    rd(`OFF_CAUSE, 32'h0000_0300, 32'h0100, "soft pending");
    wr(`OFF_CAUSE, 32'h0);
    rd(`OFF_CAUSE, 32'h0000_0300, 32'h0, "soft pending");
    wr(`OFF_STATUS, 32'h0);
    for (int j = 0; j < 2; j++) begin
      timer_match <= 1'h1;
      @(posedge aclk);
      timer_match <= 1'h0;
      rd(`OFF_CAUSE, 32'h0000_8000, 32'h8000, "timer pending");
      wr(j ? `OFF_CAUSE : `OFF_COMPARE, 32'h5);
      rd(`OFF_CAUSE, 32'h0000_8000, 32'h0, "timer pending");
    end
    $display("test interrupt done");
    end_of_test;
  end
endmodule

// >>> sim/exc_unit_monitor.sv
// Port checks for the exception unit
`timescale 1ns/1ps
`include "exc_unit_defs.vh"
module exc_unit_monitor (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire instr_valid,
  input wire [31:0] instr_word,
  input wire fpu_exception,
  input wire low_power,
  input wire exc_taken,
  input wire [4:0] exc_code,
  input wire [63:0] exc_vector,
  input wire wake
);
  wire spec = instr_valid && instr_word[31:26] == `OP_FUNCTION_FIELD_OPGROUP;
  wire sys_in = spec && instr_word[5:0] == `FN_SYSTEM_CALL_INSTR;
  wire bp_in = spec && instr_word[5:0] == `FN_BREAK;
  wire fpe_in = instr_valid && fpu_exception;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken early");
  chk_sys_cause: assert property (
    exc_taken && exc_code == `EXC_SYS |-> $past(sys_in)) else $error("bad sys code");
  chk_bp_cause: assert property (
    exc_taken && exc_code == `EXC_BP |-> $past(bp_in)) else $error("bad bp code");
  chk_fpe_cause: assert property (
    exc_taken && exc_code == `EXC_FPE |-> $past(fpe_in)) else $error("bad fpe code");
  chk_vector_form: assert property (exc_taken |->
    exc_vector[31:0] inside {`VEC_NORMAL, `VEC_BOOT} && exc_vector[63:32] inside {32'h0, `VEC_SEXT})
    else $error("bad vector");
  chk_wake_cause: assert property (wake |-> $past(low_power))
    else $error("wake without doze");
  cov_sys: cover property (exc_taken && exc_code == `EXC_SYS);
  cov_int: cover property (exc_taken && exc_code == `EXC_INT);
  cov_wake: cover property (wake);
endmodule
bind exc_unit exc_unit_monitor exc_unit_monitor_i (.*);

// >>> sim/irq_source.sv
// External interrupt request lines model
`timescale 1ns/1ps
module irq_source (
  input wire aclk,
  input wire [5:0] raise,
  input wire [5:0] drop,
  output logic [5:0] hw_int_n
);
  initial hw_int_n = 6'h3F;
  // Active low, held until the cause is dropped
  always @(posedge aclk) begin
    hw_int_n <= (hw_int_n & ~raise) | drop;
  end
endmodule
